// ### src/idle_command_standby_timer.sv
`timescale 1ns/1ps
module idle_command_standby_timer
    import idle_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter logic        DEV_SEL  = 1'b0
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       soft_reset_in,
    input  wire logic [2:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       spindle_at_speed_in,
    output logic      [7:0] reg_rdata_out,
    output logic            spindle_run_out,
    output logic            standby_out,
    output logic            timer_armed_out
);

    logic             clr;
    logic             access;
    logic             cmd_wr;
    logic             is_idle_op;
    logic             accept;
    logic             reject;
    logic             tick;
    logic             expire;
    logic [SEC_W-1:0] decoded;
    logic [7:0]       status;
    logic [7:0]       rd_mux;

    cmd_state_e       state_q;
    logic [7:0]       sc_q;
    logic [7:0]       dh_q;
    logic             busy_q;
    logic             err_q;
    logic             abrt_q;
    logic [SEC_W-1:0] timer_q;
    logic [SEC_W-1:0] interval_q;

    // Hard and soft reset both return to the power-on state
    assign clr        = !rst_n_in || soft_reset_in;
    assign access     = reg_wr_in || reg_rd_in;
    assign cmd_wr     = reg_wr_in && (reg_addr_in == ADDR_CMD)
                        && (dh_q[DH_DEV_BIT] == DEV_SEL) && !busy_q;
    assign is_idle_op = (reg_wdata_in == OP_IDLE_A) || (reg_wdata_in == OP_IDLE_B);
    assign accept     = cmd_wr && is_idle_op;
    assign reject     = cmd_wr && !is_idle_op;
    // Count ends on the tick that takes it from one to zero
    assign expire     = timer_armed_out && !standby_out && tick && (timer_q == SEC_W'(1))
                        && !access;

    timeout_decode u_decode (
        .sc_in       (sc_q),
        .seconds_out (decoded)
    );

    sec_tick #(
        .CYCLES (TICK_CYC)
    ) u_tick (
        .clk_in     (clk_in),
        .clr_in     (clr),
        .restart_in (accept || access),
        .tick_out   (tick)
    );

    // Task-file parameter registers
    always_ff @(posedge clk_in) begin
        if (clr) begin
            sc_q <= REG_RESET;
            dh_q <= REG_RESET;
        end else if (reg_wr_in && !busy_q) begin
            if (reg_addr_in == ADDR_SECCNT) begin
                sc_q <= reg_wdata_in;
            end
            if (reg_addr_in == ADDR_DEVHEAD) begin
                dh_q <= reg_wdata_in;
            end
        end
    end

    // Command sequencing and completion status
    always_ff @(posedge clk_in) begin
        if (clr) begin
            state_q <= CMD_READY;
            busy_q  <= 1'b0;
            err_q   <= 1'b0;
            abrt_q  <= 1'b0;
        end else begin
            case (state_q)
                CMD_READY: begin
                    if (accept) begin
                        err_q  <= 1'b0;
                        abrt_q <= 1'b0;
                        if (!spindle_at_speed_in) begin
                            state_q <= CMD_SPINUP;
                            busy_q  <= 1'b1;
                        end
                    end else if (reject) begin
                        err_q  <= 1'b1;
                        abrt_q <= 1'b1;
                    end
                end
                CMD_SPINUP: begin
                    if (spindle_at_speed_in) begin
                        state_q <= CMD_READY;
                        busy_q  <= 1'b0;
                    end
                end
                default: begin
                    state_q <= CMD_READY;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // Power mode and spindle drive
    always_ff @(posedge clk_in) begin
        if (clr) begin
            standby_out     <= 1'b1;
            spindle_run_out <= 1'b0;
        end else if (accept) begin
            standby_out     <= 1'b0;
            spindle_run_out <= 1'b1;
        end else if (expire) begin
            standby_out     <= 1'b1;
            spindle_run_out <= 1'b0;
        end
    end

    // Standby timer in whole seconds
    always_ff @(posedge clk_in) begin
        if (clr) begin
            timer_q         <= '0;
            interval_q      <= '0;
            timer_armed_out <= 1'b0;
        end else if (accept) begin
            timer_q         <= decoded;
            interval_q      <= decoded;
            timer_armed_out <= (sc_q != SC_OFF);
        end else if (timer_armed_out && !standby_out && access) begin
            timer_q <= interval_q;
        end else if (timer_armed_out && !standby_out && tick && (timer_q != '0)) begin
            timer_q <= timer_q - SEC_W'(1);
        end
    end

    // Status: ready and seek complete whenever not busy; no fault source here
    always_comb begin
        status         = '0;
        status[ST_BSY] = busy_q;
        status[ST_RDY] = !busy_q;
        status[ST_DF]  = 1'b0;
        status[ST_DSC] = !busy_q;
        status[ST_ERR] = err_q;
    end

    always_comb begin
        case (reg_addr_in)
            ADDR_ERROR:   rd_mux = 8'(abrt_q) << ER_ABRT;
            ADDR_SECCNT:  rd_mux = sc_q;
            ADDR_DEVHEAD: rd_mux = dh_q;
            ADDR_CMD:     rd_mux = status;
            default:      rd_mux = REG_RESET;
        endcase
    end

    // Read data registered so the output comes from a flop
    always_ff @(posedge clk_in) begin
        if (clr) begin
            reg_rdata_out <= REG_RESET;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    property p_opcode;
        @(posedge clk_in) disable iff (clr)
        (reg_wr_in && reg_addr_in == ADDR_CMD && !busy_q && dh_q[DH_DEV_BIT] == DEV_SEL
         && (reg_wdata_in == OP_IDLE_A || reg_wdata_in == OP_IDLE_B))
        |=> !standby_out && spindle_run_out && !err_q;
    endproperty
    a_opcode: assert property (p_opcode) else $error("idle opcode not accepted");

    property p_load;
        @(posedge clk_in) disable iff (clr)
        accept |=> timer_q == $past(decoded) && interval_q == $past(decoded);
    endproperty
    a_load: assert property (p_load) else $error("timer not loaded on idle");

    property p_count;
        @(posedge clk_in) disable iff (clr)
        (timer_armed_out && !standby_out && tick && !access && !accept && timer_q > SEC_W'(1))
        |=> timer_q == $past(timer_q) - SEC_W'(1);
    endproperty
    a_count: assert property (p_count) else $error("timer did not decrement");

    property p_spinup;
        @(posedge clk_in) disable iff (clr)
        (accept && !spindle_at_speed_in) |=> busy_q && spindle_run_out;
    endproperty
    a_spinup: assert property (p_spinup) else $error("spin-up not started");

    property p_no_spinup;
        @(posedge clk_in) disable iff (clr)
        (accept && spindle_at_speed_in) |=> !busy_q;
    endproperty
    a_no_spinup: assert property (p_no_spinup) else $error("needless spin-up wait");

    property p_idle_spin;
        @(posedge clk_in) disable iff (clr)
        !standby_out |-> spindle_run_out;
    endproperty
    a_idle_spin: assert property (p_idle_spin) else $error("spindle stopped in idle");

    property p_disable;
        @(posedge clk_in) disable iff (clr)
        (accept && sc_q == SC_OFF) |=> !timer_armed_out ##1 !standby_out;
    endproperty
    a_disable: assert property (p_disable) else $error("zero count armed timer");

    property p_short;
        @(posedge clk_in) disable iff (clr)
        (accept && sc_q != SC_OFF && sc_q <= SC_SHORT_MAX)
        |=> timer_q == SEC_W'($past(sc_q)) * SHORT_STEP_SEC;
    endproperty
    a_short: assert property (p_short) else $error("short timeout wrong");

    property p_long;
        @(posedge clk_in) disable iff (clr)
        (accept && sc_q > SC_SHORT_MAX && sc_q <= SC_LONG_MAX)
        |=> timer_q == (SEC_W'($past(sc_q)) - SEC_W'(SC_SHORT_MAX)) * LONG_STEP_SEC;
    endproperty
    a_long: assert property (p_long) else $error("long timeout wrong");

    property p_special;
        @(posedge clk_in) disable iff (clr)
        (accept && sc_q == SC_8H) |=> timer_q == TO_8H_SEC && timer_armed_out;
    endproperty
    a_special: assert property (p_special) else $error("eight hour timeout wrong");

    property p_odd;
        @(posedge clk_in) disable iff (clr)
        (accept && sc_q > SC_8H) |=> timer_q > TO_21M_SEC && timer_q <= TO_21M15_SEC;
    endproperty
    a_odd: assert property (p_odd) else $error("21 minute variant wrong");

    property p_expire;
        @(posedge clk_in) disable iff (clr)
        expire && !accept |=> standby_out && !spindle_run_out && timer_q == '0;
    endproperty
    a_expire: assert property (p_expire) else $error("no standby on expiry");

    property p_reload;
        @(posedge clk_in) disable iff (clr)
        (timer_armed_out && !standby_out && access && !accept) |=> timer_q == interval_q;
    endproperty
    a_reload: assert property (p_reload) else $error("access did not reload");

    property p_reject;
        @(posedge clk_in) disable iff (clr)
        reject |=> err_q && abrt_q && $stable(standby_out);
    endproperty
    a_reject: assert property (p_reject) else $error("rejected command not flagged");

endmodule

// ### inc/idle_pkg.sv
package idle_pkg;

    localparam int unsigned SEC_W = 16;

    // Task-file addresses
    localparam logic [2:0] ADDR_ERROR   = 3'h1;
    localparam logic [2:0] ADDR_SECCNT  = 3'h2;
    localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
    localparam logic [2:0] ADDR_CMD     = 3'h7;

    localparam logic [7:0] OP_IDLE_A = 8'hE3;
    localparam logic [7:0] OP_IDLE_B = 8'h97;

    localparam int unsigned DH_DEV_BIT = 4;

    // Status and error bit positions
    localparam int unsigned ST_BSY  = 7;
    localparam int unsigned ST_RDY  = 6;
    localparam int unsigned ST_DF   = 5;
    localparam int unsigned ST_DSC  = 4;
    localparam int unsigned ST_ERR  = 0;
    localparam int unsigned ER_ABRT = 2;

    localparam logic [7:0] REG_RESET = 8'h00;

    // Sector count encodings
    localparam logic [7:0] SC_OFF       = 8'h00;
    localparam logic [7:0] SC_SHORT_MAX = 8'hF0;
    localparam logic [7:0] SC_LONG_MAX  = 8'hFB;
    localparam logic [7:0] SC_21M       = 8'hFC;
    localparam logic [7:0] SC_8H        = 8'hFD;
    localparam logic [7:0] SC_21M10     = 8'hFE;

    localparam logic [SEC_W-1:0] SEC_PER_MIN    = 16'h003C;
    localparam logic [SEC_W-1:0] SEC_PER_HOUR   = 16'h0E10;
    localparam logic [SEC_W-1:0] SHORT_STEP_SEC = 16'h0005;
    localparam logic [SEC_W-1:0] LONG_STEP_MIN  = 16'h001E;
    localparam logic [SEC_W-1:0] LONG_STEP_SEC  = LONG_STEP_MIN * SEC_PER_MIN;
    localparam logic [SEC_W-1:0] TO_21M_SEC     = 16'h0015 * SEC_PER_MIN;
    localparam logic [SEC_W-1:0] TO_8H_SEC      = 16'h0008 * SEC_PER_HOUR;
    localparam logic [SEC_W-1:0] TO_21M10_SEC   = TO_21M_SEC + 16'h000A;
    localparam logic [SEC_W-1:0] TO_21M15_SEC   = TO_21M_SEC + 16'h000F;

    // One-second timer granularity
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic {
        CMD_READY,
        CMD_SPINUP
    } cmd_state_e;

endpackage

// ### src/sec_tick.sv
`timescale 1ns/1ps
module sec_tick
    import idle_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic clr_in,
    input  wire logic restart_in,
    output logic      tick_out
);

    logic [31:0] cnt_q;

    // Restart aligns the first tick to a full period after a reload
    always_ff @(posedge clk_in) begin
        if (clr_in || restart_in) begin
            cnt_q <= 32'h0000_0000;
        end else if (cnt_q == 32'(CYCLES - 1)) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr_in || restart_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_q == 32'(CYCLES - 1));
        end
    end

endmodule

// ### src/timeout_decode.sv
`timescale 1ns/1ps
module timeout_decode
    import idle_pkg::*;
(
    input  wire logic [7:0]       sc_in,
    output logic      [SEC_W-1:0] seconds_out
);

    always_comb begin
        if (sc_in == SC_OFF) begin
            seconds_out = '0;
        end else if (sc_in <= SC_SHORT_MAX) begin
            seconds_out = SEC_W'(sc_in) * SHORT_STEP_SEC;
        end else if (sc_in <= SC_LONG_MAX) begin
            seconds_out = (SEC_W'(sc_in) - SEC_W'(SC_SHORT_MAX)) * LONG_STEP_SEC;
        end else if (sc_in == SC_21M) begin
            seconds_out = TO_21M_SEC;
        end else if (sc_in == SC_8H) begin
            seconds_out = TO_8H_SEC;
        end else if (sc_in == SC_21M10) begin
            seconds_out = TO_21M10_SEC;
        end else begin
            seconds_out = TO_21M15_SEC;
        end
    end

endmodule

// ### tb/host_adapter_model.sv
`timescale 1ns/1ps
module host_adapter_model
    import idle_pkg::*;
(
    input  wire logic       clk_in,
    output logic      [2:0] reg_addr_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic      [7:0] reg_wdata_out,
    input  wire logic [7:0] reg_rdata_in
);
    initial begin
        reg_addr_out  = 3'h0;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        reg_wdata_out = 8'h00;
    end
    // Released bus shows inverted leftovers, so stale values differ from the last ones driven
    task automatic access(input logic [2:0] addr, input logic wr, input logic [7:0] data);
        @(negedge clk_in);
        reg_addr_out  = addr;
        reg_wdata_out = data;
        reg_wr_out    = wr;
        reg_rd_out    = !wr;
        @(negedge clk_in);
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        reg_addr_out  = ~addr;
        reg_wdata_out = ~data;
    endtask
    task automatic wr(input logic [2:0] addr, input logic [7:0] data);
        access(addr, 1'b1, data);
    endtask
    task automatic rd(input logic [2:0] addr, output logic [7:0] data);
        access(addr, 1'b0, 8'h00);
        @(negedge clk_in);
        data = reg_rdata_in;
    endtask
    // Parameters first, opcode last
    task automatic issue(input logic [7:0] sc, input logic [7:0] dh, input logic [7:0] op);
        wr(ADDR_SECCNT, sc);
        wr(ADDR_DEVHEAD, dh);
        wr(ADDR_CMD, op);
    endtask
endmodule

// ### tb/test_idle_command_standby_timer.sv
`timescale 1ns/1ps
module test_idle_command_standby_timer
    import idle_pkg::*;
();
    // Short tick keeps the long encodings inside the run budget
    localparam int unsigned TICK = 4;
    logic       clk_in;
    logic       rst_n_in;
    logic       soft_reset_in;
    logic [2:0] reg_addr_in;
    logic       reg_wr_in;
    logic       reg_rd_in;
    logic [7:0] reg_wdata_in;
    logic       spindle_at_speed_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic       spindle_run_out;
    logic       standby_out;
    logic       timer_armed_out;
    int         err_total;
    int         total_checks;
    int         spin_cnt;
    int         coast_cnt;
    logic [7:0] rd_val;

    idle_command_standby_timer #(.TICK_CYC(TICK), .DEV_SEL(1'b0)) u_idle_command_standby_timer (
        .clk_in              (clk_in),
        .rst_n_in            (rst_n_in),
        .soft_reset_in       (soft_reset_in),
        .reg_addr_in         (reg_addr_in),
        .reg_wr_in           (reg_wr_in),
        .reg_rd_in           (reg_rd_in),
        .reg_wdata_in        (reg_wdata_in),
        .spindle_at_speed_in (spindle_at_speed_in),
        .reg_rdata_out       (reg_rdata_out),
        .spindle_run_out     (spindle_run_out),
        .standby_out         (standby_out),
        .timer_armed_out     (timer_armed_out)
    );
    host_adapter_model u_host_adapter_model (
        .clk_in        (clk_in),
        .reg_addr_out  (reg_addr_in),
        .reg_wr_out    (reg_wr_in),
        .reg_rd_out    (reg_rd_in),
        .reg_wdata_out (reg_wdata_in),
        .reg_rdata_in  (reg_rdata_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Spindle reaches speed after 8 cycles and coasts 40 cycles after stop
    always @(negedge clk_in) begin
        if (spindle_run_out === 1'b1) begin
            coast_cnt <= 0;
            if (spin_cnt == 8) spindle_at_speed_in <= 1'b1;
            else spin_cnt <= spin_cnt + 1;
        end else begin
            spin_cnt <= 0;
            if (coast_cnt == 40) spindle_at_speed_in <= 1'b0;
            else coast_cnt <= coast_cnt + 1;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rd_check(input logic [2:0] addr, input logic [7:0] exp, input string msg);
        u_host_adapter_model.rd(addr, rd_val);
        check(rd_val, exp, msg);
    endtask
    task automatic bits(input logic sb, input logic run, input logic armed);
        check({5'h00, standby_out, spindle_run_out, timer_armed_out}, {5'h00, sb, run, armed}, "mode");
    endtask
    // Standby is due one negedge after the last of cyc negedges; armed stays set in standby
    task automatic expect_expiry(input int cyc);
        int k;
        repeat (cyc) @(negedge clk_in);
        check({7'h00, standby_out}, 8'h00, "early standby");
        k = 0;
        while (standby_out !== 1'b1 && k < 4) begin
            @(negedge clk_in);
            k++;
        end
        bits(1'b1, 1'b0, 1'b1);
        if (standby_out !== 1'b1) results();
    endtask

    task automatic sc_reset();
        bits(1'b1, 1'b0, 1'b0);
        rd_check(ADDR_CMD, 8'h50, "status");
        rd_check(ADDR_ERROR, 8'h00, "error");
        rd_check(ADDR_SECCNT, 8'h00, "count");
        rd_check(ADDR_DEVHEAD, 8'h00, "devhead");
        rd_check(3'h3, 8'h00, "unmapped");
    endtask
    task automatic sc_abort();
        u_host_adapter_model.issue(8'h05, 8'hA0, 8'h00);
        rd_check(ADDR_CMD, 8'h51, "abort status");
        rd_check(ADDR_ERROR, 8'h04, "abort error");
        rd_check(ADDR_SECCNT, 8'h05, "count kept");
        bits(1'b1, 1'b0, 1'b0);
        u_host_adapter_model.issue(8'h00, 8'hB0, OP_IDLE_A);
        bits(1'b1, 1'b0, 1'b0);
    endtask
    task automatic sc_spinup();
        int k;
        u_host_adapter_model.issue(8'h00, 8'hA0, OP_IDLE_A);
        bits(1'b0, 1'b1, 1'b0);
        rd_check(ADDR_CMD, 8'h80, "busy");
        u_host_adapter_model.wr(ADDR_SECCNT, 8'hAA);
        k = 0;
        do begin
            u_host_adapter_model.rd(ADDR_CMD, rd_val);
            k++;
        end while (rd_val !== 8'h50 && k < 20);
        check(rd_val, 8'h50, "ready");
        if (rd_val !== 8'h50) results();
        rd_check(ADDR_SECCNT, 8'h00, "busy write");
    endtask
    // Both opcodes; spindle still turning so no busy phase
    task automatic sc_opcodes();
        logic [7:0] ops [2];
        ops = '{OP_IDLE_A, OP_IDLE_B};
        foreach (ops[i]) begin
            u_host_adapter_model.issue(8'h01, 8'hA0, ops[i]);
            rd_check(ADDR_CMD, 8'h50, "no spin wait");
            bits(1'b0, 1'b1, 1'b1);
            expect_expiry(5 * TICK - 1);
        end
    endtask
    task automatic sc_disable();
        u_host_adapter_model.issue(8'h00, 8'hA0, OP_IDLE_B);
        repeat (60) @(negedge clk_in);
        bits(1'b0, 1'b1, 1'b0);
    endtask
    task automatic sc_reload();
        u_host_adapter_model.issue(8'h02, 8'hA0, OP_IDLE_A);
        repeat (30) @(negedge clk_in);
        rd_check(ADDR_SECCNT, 8'h02, "count");
        expect_expiry(10 * TICK - 1);
    endtask
    task automatic sc_table();
        logic [7:0] scs [6];
        int         secs [6];
        scs  = '{8'hF0, 8'hF1, 8'hFC, 8'hFE, 8'hFF, 8'h01};
        secs = '{1200, 1800, 1260, 1270, 1275, 5};
        foreach (scs[i]) begin
            u_host_adapter_model.issue(scs[i], 8'hA0, OP_IDLE_A);
            expect_expiry(secs[i] * TICK);
        end
        // Eight hours is too long to run out; only outlasting 21 minutes is shown
        u_host_adapter_model.issue(8'hFD, 8'hA0, OP_IDLE_A);
        repeat (1300 * TICK) @(negedge clk_in);
        bits(1'b0, 1'b1, 1'b1);
    endtask
    task automatic sc_soft();
        soft_reset_in = 1'b1;
        @(negedge clk_in);
        soft_reset_in = 1'b0;
        bits(1'b1, 1'b0, 1'b0);
        rd_check(ADDR_SECCNT, 8'h00, "soft count");
    endtask

    initial begin
        rst_n_in            = 1'b0;
        soft_reset_in       = 1'b0;
        err_total           = 0;
        total_checks        = 0;
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        sc_reset();
        sc_abort();
        sc_spinup();
        sc_opcodes();
        sc_disable();
        sc_reload();
        sc_table();
        sc_soft();
        results();
    end
endmodule
